//--- msc_csr.sv
// Miscellaneous system registers: pattern, config, timer, free counter
// Summary of operation
// - Pattern register returns fixed 87654321h
// - Pattern readable unready; never valid during reset
// - Either 16-bit half readable on its own
// - Ready bit 27 set after stabilising from reset
// - Ready rise raises interrupt when enabled
// - Hardware config pollable while unready; reads during reset unanswered
// - Bits 26:25 latch straps; loader may rewrite
// - PHY override bits override latched straps
// - Bit 29 runs timer; clear halts; resets 0
// - Enable falling edge forces preload to FFFFh
// - Preload bits 15:0 give countdown start value
// - Timer raises periodic interrupts every preload+1 ticks
// - Count register shows live value, resets FFFFh
// - 32-bit counter from zero at 25 MHz
// - Free counter wraps to zero and continues
// - Free counter clears within 160 ns
`timescale 1ns/1ps
module msc_csr
  import msc_pkg::*;
#(
  parameter int READY_CYCLES = READY_CYC,
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic dig_rst,
  // Register access from the serial management front end
  input wire msc_req_s acc,
  output logic [31:0] rd_data_q,
  output logic rd_valid_q,
  // Straps and loader
  input wire logic [1:0] strap_in,
  input wire logic eep_wr,
  input wire logic [1:0] eep_strap,
  // Port PHY crossover overrides
  input wire logic [1:0] ovr_ctrl,
  input wire logic [1:0] ovr_state,
  output logic [1:0] crossover_en_q,
  // Events for the interrupt controller
  input wire logic ready_irq_en,
  output logic ready_q,
  output logic ready_irq_q,
  output logic timer_irq_q
);

  localparam logic [15:0] READY_LAST = 16'(READY_CYCLES - 1);
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  if (READY_CYCLES < 1 || READY_CYCLES > 65536)
  begin : g_bad_ready
    $error("msc_csr READY_CYCLES out of range");
  end
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536)
  begin : g_bad_tick
    $error("msc_csr TICK_CYCLES out of range");
  end

  msc_main_s q;
  msc_main_s d;
  logic [31:0] free_cnt;
  logic cfg_wr;
  logic new_en;

  msc_free_count u_free (
    .clk(clk),
    .rst_n(rst_n),
    .srst(dig_rst),
    .count_q(free_cnt)
  );

  // Assemble the full 32-bit word of a register
  function automatic logic [31:0] read_word(input logic [8:0] a,
                                            input msc_main_s s,
                                            input logic [31:0] fr);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      OFF_PATTERN: w = PATTERN_VAL;
      OFF_HARDWARE_CONFIG:
      begin
        w[READY_BIT] = s.ready;
        w[STRAP2_BIT] = s.strap[1];
        w[STRAP1_BIT] = s.strap[0];
      end
      OFF_TMR_CFG:
      begin
        w[TIMER_EN_BIT] = s.tmr_en;
        w[15:0] = s.preload;
      end
      OFF_TMR_CNT: w[15:0] = s.count;
      OFF_FREE_CNT: w = fr;
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction : read_word

  // Writes are refused until ready
  assign cfg_wr = acc.wr && q.ready && acc.addr == OFF_TMR_CFG;
  assign new_en = acc.wdata[TIMER_EN_BIT];

  always_comb
  begin
    logic [31:0] word;
    word = read_word(acc.addr, q, free_cnt);
    d = q;
    d.rd_valid = 1'b0;
    d.tmr_irq = 1'b0;
    d.rdy_irq = 1'b0;

    // Strap capture at reset release, loader rewrite afterwards
    if (q.strap_hold)
    begin
      d.strap = strap_in;
      d.strap_hold = 1'b0;
    end
    else if (eep_wr)
    begin
      d.strap = eep_strap;
    end

    // Effective crossover enable towards the PHYs
    for (int i = 0; i < 2; i++)
    begin
      d.xover[i] = ovr_ctrl[i] ? ovr_state[i] : q.strap[i];
    end

    // Ready after a settling delay
    if (!q.ready)
    begin
      if (q.rdy_cnt == READY_LAST)
      begin
        d.ready = 1'b1;
        d.rdy_irq = ready_irq_en;
      end
      else
      begin
        d.rdy_cnt = q.rdy_cnt + 16'h0001;
      end
    end

    // General timer countdown
    if (q.tmr_en)
    begin
      if (q.pre_cnt == TICK_LAST)
      begin
        d.pre_cnt = 16'h0000;
        if (q.count == 16'h0000)
        begin
          d.count = q.preload;
          d.tmr_irq = 1'b1;
        end
        else
        begin
          d.count = q.count - 16'h0001;
        end
      end
      else
      begin
        d.pre_cnt = q.pre_cnt + 16'h0001;
      end
    end

    // Timer configuration write
    if (cfg_wr)
    begin
      d.tmr_en = new_en;
      d.preload = acc.wdata[15:0];
      if (q.tmr_en && !new_en)
      begin
        d.preload = PRELOAD_RST;
      end
      if (!q.tmr_en && new_en)
      begin
        d.count = acc.wdata[15:0];
        d.pre_cnt = 16'h0000;
      end
    end

    // Register read, full word or either half alone
    if (acc.rd)
    begin
      d.rd_valid = 1'b1;
      if (acc.half)
      begin
        d.rd_data = {16'h0000, acc.hi ? word[31:16] : word[15:0]};
      end
      else
      begin
        d.rd_data = word;
      end
    end

    // Digital reset returns everything to reset values
    if (dig_rst)
    begin
      d = MAIN_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= MAIN_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign rd_data_q = q.rd_data;
  assign rd_valid_q = q.rd_valid;
  assign crossover_en_q = q.xover;
  assign ready_q = q.ready;
  assign ready_irq_q = q.rdy_irq;
  assign timer_irq_q = q.tmr_irq;

  // Named steps of the timer behaviour and of full register reads
  sequence s_cfg_write(logic en);
    cfg_wr && new_en == en && !dig_rst;
  endsequence

  sequence s_zero_tick;
    q.tmr_en && q.count == 16'h0000 && q.pre_cnt == TICK_LAST &&
      !cfg_wr && !dig_rst;
  endsequence

  sequence s_full_read(logic [8:0] a);
    acc.rd && !acc.half && acc.addr == a && !dig_rst;
  endsequence

  pattern_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_full_read(OFF_PATTERN) |=> rd_valid_q && rd_data_q == PATTERN_VAL)
    else $error("pattern read returned wrong data");

  reset_pattern_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    dig_rst |=> rd_data_q != PATTERN_VAL)
    else $error("valid pattern shown during reset");

  half_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc.rd && acc.half && acc.hi && acc.addr == OFF_PATTERN && !dig_rst
    |=> rd_valid_q && rd_data_q == 32'h00008765)
    else $error("upper half read wrong");

  ready_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    dig_rst |=> !ready_q ##1 !ready_q)
    else $error("ready set too early after reset");

  ready_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ready_q && !dig_rst |=> ready_q)
    else $error("ready dropped without a reset");

  ready_irq_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(ready_q) |-> ready_irq_q == $past(ready_irq_en))
    else $error("ready interrupt not matched to enable");

  read_answer_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    acc.rd && !dig_rst |=> rd_valid_q)
    else $error("read not answered");

  valid_pulse_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !acc.rd |=> !rd_valid_q)
    else $error("read valid without a read");

  hwcfg_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_full_read(OFF_HARDWARE_CONFIG) |=> rd_data_q[READY_BIT] == $past(ready_q) &&
      rd_data_q[STRAP2_BIT:STRAP1_BIT] == $past(q.strap))
    else $error("hardware config read wrong");

  strap_capture_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.strap_hold && !dig_rst |=> q.strap == $past(strap_in))
    else $error("strap level not captured");

  loader_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !q.strap_hold && eep_wr && !dig_rst |=> q.strap == $past(eep_strap))
    else $error("loader did not rewrite straps");

  xover_ovr_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    ovr_ctrl[0] && !dig_rst |=> crossover_en_q[0] == $past(ovr_state[0]))
    else $error("crossover override ignored");

  xover_strap_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !ovr_ctrl[1] && !dig_rst |=> crossover_en_q[1] == $past(q.strap[1]))
    else $error("crossover strap not passed through");

  halt_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !q.tmr_en && !cfg_wr && !dig_rst |=> q.count == $past(q.count))
    else $error("timer moved while halted");

  cfg_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_full_read(OFF_TMR_CFG) |=> rd_data_q ==
      {2'b00, $past(q.tmr_en), 13'h0000, $past(q.preload)})
    else $error("timer config read wrong");

  preload_force_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.tmr_en ##0 s_cfg_write(1'b0) |=> q.preload == PRELOAD_RST && !q.tmr_en)
    else $error("preload not forced on disable");

  start_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !q.tmr_en ##0 s_cfg_write(1'b1)
    |=> q.tmr_en && q.count == $past(acc.wdata[15:0]))
    else $error("timer did not start from preload");

  tick_step_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.tmr_en && q.pre_cnt == TICK_LAST && q.count != 16'h0000 &&
      !cfg_wr && !dig_rst |=> q.count == $past(q.count) - 16'h0001)
    else $error("timer did not step down");

  reload_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_zero_tick |=> timer_irq_q && q.count == $past(q.preload))
    else $error("timer did not reload at zero");

  irq_zero_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    timer_irq_q |-> $past(q.count) == 16'h0000)
    else $error("timer event away from zero");

  count_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_full_read(OFF_TMR_CNT) |=> rd_data_q == {16'h0000, $past(q.count)})
    else $error("timer count read wrong");

  dig_values_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    dig_rst |=> q.count == COUNT_RST && q.preload == PRELOAD_RST &&
      !q.tmr_en)
    else $error("timer not back to reset values");

  free_read_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    s_full_read(OFF_FREE_CNT) |=> rd_data_q == $past(free_cnt))
    else $error("free count read wrong");

endmodule : msc_csr

//--- msc_free_count.sv
// Free-running 32-bit counter advancing at 25 MHz
`timescale 1ns/1ps
module msc_free_count
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic srst,
  // Count
  output logic [31:0] count_q
);

  msc_free_s q;
  msc_free_s d;

  if (FREE_DIV != 2)
  begin : g_bad_div
    $error("msc_free_count serves only a divide by two");
  end

  always_comb
  begin
    d = q;
    d.phase = ~q.phase;
    if (q.phase)
    begin
      d.count = q.count + 32'h00000001;
    end
    if (srst)
    begin
      d = FREE_STATE_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= FREE_STATE_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign count_q = q.count;

  free_step_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    q.phase && !srst |=> count_q == $past(count_q) + 32'h00000001)
    else $error("free count did not step");

  free_hold_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    !q.phase && !srst |=> count_q == $past(count_q))
    else $error("free count stepped faster than 25 MHz");

  free_clear_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    srst |=> count_q == FREE_RST)
    else $error("free count not cleared after reset");

endmodule : msc_free_count

//--- msc_host.sv
// Host model issuing register accesses over the management port
`timescale 1ns/1ps
module msc_host
  import msc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  input wire logic ready_q,
  input wire logic [31:0] rd_data_q,
  input wire logic rd_valid_q,
  output msc_req_s acc
);
  initial acc = '0;
  task automatic rd(input logic [8:0] a, input logic hf, input logic h,
                    output logic [31:0] d);
    @(posedge clk);
    acc <= '{1'b1, 1'b0, hf, h, a, 32'h0};
    @(posedge clk);
    acc <= '0;
    #1;
    d = rd_valid_q ? rd_data_q : 32'hxxxxxxxx;
  endtask : rd
  // Writes wait for the ready flag
  task automatic wr(input logic [8:0] a, input logic [31:0] v);
    int n;
    n = 0;
    while (ready_q !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    acc <= '{1'b0, 1'b1, 1'b0, 1'b0, a, v};
    @(posedge clk);
    acc <= '0;
  endtask : wr
  // Poll the pattern until reset has finished
  task automatic poll(output int n);
    logic [31:0] d;
    n = 0;
    d = '0;
    while (d !== PATTERN_VAL && n < 64)
    begin
      rd(OFF_PATTERN, 1'b0, 1'b0, d);
      n++;
    end
  endtask : poll
endmodule : msc_host

//--- msc_pkg.sv
// Package of constants and types for the miscellaneous system registers
package msc_pkg;

  // Register byte offsets
  localparam logic [8:0] OFF_PATTERN = 9'h064;
  localparam logic [8:0] OFF_HARDWARE_CONFIG = 9'h074;
  localparam logic [8:0] OFF_TMR_CFG = 9'h08c;
  localparam logic [8:0] OFF_TMR_CNT = 9'h090;
  localparam logic [8:0] OFF_FREE_CNT = 9'h09c;

  // Field positions
  localparam int READY_BIT = 27;
  localparam int STRAP2_BIT = 26;
  localparam int STRAP1_BIT = 25;
  localparam int TIMER_EN_BIT = 29;

  // Reset and fixed values
  localparam logic [31:0] PATTERN_VAL = 32'h87654321;
  localparam logic [15:0] PRELOAD_RST = 16'hffff;
  localparam logic [15:0] COUNT_RST = 16'hffff;
  localparam logic [31:0] FREE_RST = 32'h00000000;

  // Timing
  localparam int CLK_MHZ = 50;
  localparam int FREE_MHZ = 25;
  localparam int FREE_DIV = CLK_MHZ / FREE_MHZ;
  localparam int FREE_SETTLE_NS = 160;
  localparam int FREE_SETTLE_CYC = (FREE_SETTLE_NS * CLK_MHZ) / 1000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
  localparam int READY_CYC = 16;

  // Register access request from the serial management front end
  typedef struct packed {
    logic rd;
    logic wr;
    logic half;
    logic hi;
    logic [8:0] addr;
    logic [31:0] wdata;
  } msc_req_s;

  // State of the register bank
  typedef struct packed {
    logic ready;
    logic [15:0] rdy_cnt;
    logic strap_hold;
    logic [1:0] strap;
    logic [1:0] xover;
    logic tmr_en;
    logic [15:0] preload;
    logic [15:0] count;
    logic [15:0] pre_cnt;
    logic tmr_irq;
    logic rdy_irq;
    logic [31:0] rd_data;
    logic rd_valid;
  } msc_main_s;

  localparam msc_main_s MAIN_RST = '{
    ready: 1'b0, rdy_cnt: 16'h0000, strap_hold: 1'b1, strap: 2'h0,
    xover: 2'h0, tmr_en: 1'b0, preload: PRELOAD_RST, count: COUNT_RST,
    pre_cnt: 16'h0000, tmr_irq: 1'b0, rdy_irq: 1'b0,
    rd_data: 32'h00000000, rd_valid: 1'b0};

  // State of the free-running counter
  typedef struct packed {
    logic phase;
    logic [31:0] count;
  } msc_free_s;

  localparam msc_free_s FREE_STATE_RST = '{phase: 1'b0, count: FREE_RST};

endpackage : msc_pkg

//--- tb.sv
// Self-checking testbench of the miscellaneous register bank
`timescale 1ns/1ps
module tb
  import msc_pkg::*;
;
  localparam int RDY = 4;
  localparam int TCK = 2;
  logic clk, rst_n, dig_rst, eep_wr, ready_irq_en;
  logic [1:0] strap_in, eep_strap, ovr_ctrl, ovr_state, crossover_en_q;
  logic [31:0] rd_data_q, seed;
  logic rd_valid_q, ready_q, ready_irq_q, timer_irq_q;
  msc_req_s acc;
  int errors, check_count, cyc, rdy_p, tmr_p, last_t, period;

  msc_csr #(.READY_CYCLES(RDY), .TICK_CYCLES(TCK)) u_dut (.clk(clk),
    .rst_n(rst_n), .dig_rst(dig_rst), .acc(acc), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .strap_in(strap_in), .eep_wr(eep_wr),
    .eep_strap(eep_strap), .ovr_ctrl(ovr_ctrl), .ovr_state(ovr_state),
    .crossover_en_q(crossover_en_q), .ready_irq_en(ready_irq_en),
    .ready_q(ready_q), .ready_irq_q(ready_irq_q),
    .timer_irq_q(timer_irq_q));
  msc_host u_host (.clk(clk), .ready_q(ready_q), .rd_data_q(rd_data_q),
    .rd_valid_q(rd_valid_q), .acc(acc));

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction : xs
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic complete_run;
    if (errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Event monitor
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (ready_irq_q === 1'b1)
      rdy_p <= rdy_p + 1;
    if (timer_irq_q === 1'b1)
    begin
      tmr_p <= tmr_p + 1;
      period <= cyc - last_t;
      last_t <= cyc;
    end
  end
  initial
  begin
    #400000;
    errors++;
    complete_run();
  end

  initial
  begin
    logic [31:0] d, e, p;
    logic [1:0] s;
    int n;
    {errors, check_count, cyc, rdy_p, tmr_p, last_t, period} = '0;
    {dig_rst, eep_wr, eep_strap, ovr_ctrl, ovr_state} = '0;
    seed = xs(32'h6abb956d);
    s = seed[1:0];
    strap_in = s;
    rst_n = 1'b0;
    ready_irq_en = 1'b1;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    u_host.rd(OFF_PATTERN, 1'b0, 1'b0, d);
    check("pattern_unready", d, PATTERN_VAL);
    u_host.rd(OFF_HARDWARE_CONFIG, 1'b0, 1'b0, d);
    check("ready_early", d[READY_BIT], 1'b0);
    check("strap", d[STRAP2_BIT:STRAP1_BIT], s);
    repeat (RDY) @(posedge clk);
    u_host.rd(OFF_HARDWARE_CONFIG, 1'b0, 1'b0, d);
    check("ready", {d[READY_BIT], ready_q}, 2'b11);
    check("ready_irq", rdy_p, 1);
    for (int h = 0; h < 2; h++)
    begin
      u_host.rd(OFF_PATTERN, 1'b1, h[0], d);
      e = h ? 32'h8765 : 32'h4321;
      check("half", d, e);
    end
    u_host.wr(OFF_PATTERN, 32'h0);
    u_host.rd(OFF_PATTERN, 1'b0, 1'b0, d);
    check("pattern", d, PATTERN_VAL);
    u_host.rd(9'h0a0, 1'b0, 1'b0, d);
    check("unmapped", d, 32'h0);
    u_host.rd(OFF_TMR_CNT, 1'b0, 1'b0, d);
    check("count_rst", d, 32'h0000ffff);
    u_host.rd(OFF_TMR_CFG, 1'b0, 1'b0, d);
    check("cfg_rst", d, 32'h0000ffff);
    seed = xs(seed);
    @(posedge clk);
    ovr_state <= seed[1:0];
    ovr_ctrl <= 2'b01;
    repeat (2) @(posedge clk);
    #1;
    check("override", crossover_en_q, {s[1], seed[0]});
    @(posedge clk);
    eep_strap <= ~s;
    eep_wr <= 1'b1;
    @(posedge clk);
    eep_wr <= 1'b0;
    u_host.rd(OFF_HARDWARE_CONFIG, 1'b0, 1'b0, d);
    check("loader", d[STRAP2_BIT:STRAP1_BIT], 2'(~s));
    u_host.rd(OFF_FREE_CNT, 1'b0, 1'b0, e);
    u_host.rd(OFF_FREE_CNT, 1'b0, 1'b0, d);
    check("free_step", d - e, 32'h1);
    p = 32'h3 + seed[3:2];
    u_host.wr(OFF_TMR_CFG, 32'h2000_0000 | p);
    u_host.rd(OFF_TMR_CNT, 1'b0, 1'b0, d);
    check("count_start", d <= p && d + 1 >= p, 1'b1);
    u_host.rd(OFF_TMR_CFG, 1'b0, 1'b0, d);
    check("cfg_run", d, 32'h2000_0000 | p);
    repeat (3 * (p + 1) * TCK) @(posedge clk);
    #1;
    check("irq_period", period, (p + 1) * TCK);
    u_host.wr(OFF_TMR_CFG, 32'h0000_1234);
    u_host.rd(OFF_TMR_CFG, 1'b0, 1'b0, d);
    check("preload_ffff", d, 32'h0000ffff);
    n = tmr_p;
    u_host.rd(OFF_TMR_CNT, 1'b0, 1'b0, e);
    repeat (4 * TCK) @(posedge clk);
    u_host.rd(OFF_TMR_CNT, 1'b0, 1'b0, d);
    check("halted", d, e);
    check("halted_irq", tmr_p, n);
    @(posedge clk);
    dig_rst <= 1'b1;
    ready_irq_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("rst_data", rd_data_q == PATTERN_VAL, 1'b0);
    check("rst_ready", ready_q, 1'b0);
    @(posedge clk);
    dig_rst <= 1'b0;
    u_host.rd(OFF_FREE_CNT, 1'b0, 1'b0, d);
    check("free_clr", d <= FREE_SETTLE_CYC, 1'b1);
    u_host.poll(n);
    check("poll", n < 64, 1'b1);
    repeat (RDY) @(posedge clk);
    u_host.rd(OFF_TMR_CNT, 1'b0, 1'b0, d);
    check("count_rst2", d, 32'h0000ffff);
    check("ready_again", ready_q, 1'b1);
    check("ready_irq_off", rdy_p, 1);
    complete_run();
  end
endmodule : tb
